// ### rtl/qbpp_top.sv
`timescale 1ns/10ps
`include "qbpp_params.svh"

// Summary of operation
// R1 - High-address port pins come out of reset high on weak pull-ups.
// R2 - Alternate-function port pins come out of reset high on weak pull-ups.
// R3 - A latch at one leaves the pin an input; outside drivers win.
// R4 - Writing zero turns on strong pull-down until one is written or reset.
// R5 - A zero-to-one change drives strong high briefly, then weak pull-up.
// R6 - In bus mode the high-address port carries address bits eight to fifteen.
// R7 - Alternate bit 0 is serial 0 receive input, bit 1 its transmit output.
// R8 - Alternate bits 2 and 3 feed external interrupt inputs a and b.
// R9 - Alternate bits 4 and 5 feed the timer a and b count inputs.
// R10 - Alternate bit 6 drives memory write strobe, bit 7 read strobe.
// R11 - Strap low sends program fetches external; strap high uses internal ROM.
// R12 - An owned pin follows its function; the latch value is kept.
// R13 - Port reads return synchronised pin levels, not latch contents.

module qbpp_top #(
  parameter int WIDTH = `QBPP_PORT_WIDTH,
  parameter int HOLD = `QBPP_STRONG_HI_CYC
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // High-address port
  input wire logic I_HI_WR_EN,
  input wire qbpp_pkg::qbpp_byte_type I_HI_WR_DATA,
  input wire logic I_HI_ADDR_EN,
  input wire qbpp_pkg::qbpp_byte_type I_HI_ADDR,
  input wire qbpp_pkg::qbpp_byte_type I_HI_PIN_IN,
  output qbpp_pkg::qbpp_byte_type O_HI_PIN_OUT,
  output qbpp_pkg::qbpp_byte_type O_HI_PIN_OE_N,
  output qbpp_pkg::qbpp_byte_type O_HI_PULLUP,
  output qbpp_pkg::qbpp_byte_type O_HI_PIN_READ,
  output qbpp_pkg::qbpp_byte_type O_HI_LATCH,
  // Alternate-function port
  input wire logic I_AF_WR_EN,
  input wire qbpp_pkg::qbpp_byte_type I_AF_WR_DATA,
  input wire qbpp_pkg::qbpp_byte_type I_AF_ALT_EN,
  input wire logic I_SERIAL0_TRANSMIT_OUT,
  input wire logic I_XMEM_WR_STROBE_N,
  input wire logic I_XMEM_RD_STROBE_N,
  input wire qbpp_pkg::qbpp_byte_type I_AF_PIN_IN,
  output qbpp_pkg::qbpp_byte_type O_AF_PIN_OUT,
  output qbpp_pkg::qbpp_byte_type O_AF_PIN_OE_N,
  output qbpp_pkg::qbpp_byte_type O_AF_PULLUP,
  output qbpp_pkg::qbpp_byte_type O_AF_PIN_READ,
  output qbpp_pkg::qbpp_byte_type O_AF_LATCH,
  output logic O_SERIAL0_RECEIVE_IN,
  output logic O_EXT_IRQ_IN_A,
  output logic O_EXT_IRQ_IN_B,
  output logic O_TIMER_A_COUNT_IN,
  output logic O_TIMER_B_COUNT_IN,
  // Fetch source strap
  input wire logic I_EXTERNAL_FETCH_STRAP,
  output logic O_FETCH_EXTERNAL,
  output logic O_FETCH_READY
);

  import qbpp_pkg::*;

  // ============================================================
  // Helpers
  // Pin feeds the function only while the function owns it;
  // otherwise the function sees an idle high
  function automatic logic qbpp_alt_in(input logic en, input logic lvl);
    qbpp_alt_in = en ? lvl : 1'b1;
  endfunction : qbpp_alt_in

  // ============================================================
  // High-address port
  qbpp_byte_type hi_alt_sel;
  qbpp_byte_type hi_latch;
  qbpp_byte_type hi_sync;
  qbpp_byte_type hi_out;
  qbpp_byte_type hi_oe_n;
  qbpp_byte_type hi_pu;

  // Address drive is push-pull, so the bus edges are not slowed by
  // the weak pull-up
  assign hi_alt_sel = {WIDTH{I_HI_ADDR_EN}}; // R6 R12

  qbpp_port_cell #(
    .WIDTH(WIDTH),
    .HOLD(HOLD)
  ) u_hi_cell (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_wr_en(I_HI_WR_EN),
    .i_wr_data(I_HI_WR_DATA),
    .i_alt_sel(hi_alt_sel),
    .i_alt_val(I_HI_ADDR), // R6
    .i_strong_sel(hi_alt_sel),
    .i_pin_in(I_HI_PIN_IN),
    .o_latch(hi_latch),
    .o_pin_sync(hi_sync),
    .o_pin_out(hi_out),
    .o_pin_oe_n(hi_oe_n),
    .o_pullup(hi_pu)
  );

  assign O_HI_PIN_OUT = hi_out;
  assign O_HI_PIN_OE_N = hi_oe_n;
  assign O_HI_PULLUP = hi_pu;
  assign O_HI_PIN_READ = hi_sync; // R13
  assign O_HI_LATCH = hi_latch;

  // ============================================================
  // Alternate-function port
  qbpp_byte_type af_alt_val;
  qbpp_byte_type af_latch;
  qbpp_byte_type af_sync;
  qbpp_byte_type af_out;
  qbpp_byte_type af_oe_n;
  qbpp_byte_type af_pu;

  // Input functions release their pin high so the outside can drive it
  always_comb begin
    af_alt_val = 8'hFF;
    af_alt_val[`QBPP_AF_SER_TX] = I_SERIAL0_TRANSMIT_OUT; // R7
    af_alt_val[`QBPP_AF_XWR] = I_XMEM_WR_STROBE_N; // R10
    af_alt_val[`QBPP_AF_XRD] = I_XMEM_RD_STROBE_N; // R10
  end

  qbpp_port_cell #(
    .WIDTH(WIDTH),
    .HOLD(HOLD)
  ) u_af_cell (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_wr_en(I_AF_WR_EN),
    .i_wr_data(I_AF_WR_DATA),
    .i_alt_sel(I_AF_ALT_EN), // R12
    .i_alt_val(af_alt_val),
    .i_strong_sel(8'h00),
    .i_pin_in(I_AF_PIN_IN),
    .o_latch(af_latch),
    .o_pin_sync(af_sync),
    .o_pin_out(af_out),
    .o_pin_oe_n(af_oe_n),
    .o_pullup(af_pu)
  );

  assign O_AF_PIN_OUT = af_out;
  assign O_AF_PIN_OE_N = af_oe_n;
  assign O_AF_PULLUP = af_pu;
  assign O_AF_PIN_READ = af_sync; // R13
  assign O_AF_LATCH = af_latch;

  // ============================================================
  // Alternate inputs to serial, interrupt and timer logic
  // One extra register stage keeps these outputs flop-driven
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_SERIAL0_RECEIVE_IN <= 1'b1;
      O_EXT_IRQ_IN_A <= 1'b1;
      O_EXT_IRQ_IN_B <= 1'b1;
      O_TIMER_A_COUNT_IN <= 1'b1;
      O_TIMER_B_COUNT_IN <= 1'b1;
    end else begin
      O_SERIAL0_RECEIVE_IN <= qbpp_alt_in(I_AF_ALT_EN[`QBPP_AF_SER_RX],
                                          af_sync[`QBPP_AF_SER_RX]); // R7
      O_EXT_IRQ_IN_A <= qbpp_alt_in(I_AF_ALT_EN[`QBPP_AF_IRQ_A],
                                    af_sync[`QBPP_AF_IRQ_A]); // R8
      O_EXT_IRQ_IN_B <= qbpp_alt_in(I_AF_ALT_EN[`QBPP_AF_IRQ_B],
                                    af_sync[`QBPP_AF_IRQ_B]); // R8
      O_TIMER_A_COUNT_IN <= qbpp_alt_in(I_AF_ALT_EN[`QBPP_AF_TMR_A],
                                        af_sync[`QBPP_AF_TMR_A]); // R9
      O_TIMER_B_COUNT_IN <= qbpp_alt_in(I_AF_ALT_EN[`QBPP_AF_TMR_B],
                                        af_sync[`QBPP_AF_TMR_B]); // R9
    end
  end

  // ============================================================
  // Fetch source strap
  logic strap_meta_r;
  logic strap_sync_r;
  logic strap_wait_r;
  qbpp_strap_state_type strap_st_r;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      strap_meta_r <= 1'b1;
      strap_sync_r <= 1'b1;
    end else begin
      strap_meta_r <= I_EXTERNAL_FETCH_STRAP;
      strap_sync_r <= strap_meta_r;
    end
  end

  // Strap is sampled once, after the synchroniser has filled; a strap
  // moved later is ignored until the next reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      strap_st_r <= QBPP_ST_WAIT;
      strap_wait_r <= 1'b0;
      O_FETCH_EXTERNAL <= 1'b0;
      O_FETCH_READY <= 1'b0;
    end else begin
      case (strap_st_r)
        QBPP_ST_WAIT: begin
          // Two edges, so the sync flop holds the strap, not its reset value
          strap_wait_r <= 1'b1;
          if (strap_wait_r) begin
            strap_st_r <= QBPP_ST_SYNC;
          end
        end
        QBPP_ST_SYNC: begin
          O_FETCH_EXTERNAL <= ~strap_sync_r; // R11
          O_FETCH_READY <= 1'b1;
          strap_st_r <= QBPP_ST_DONE;
        end
        QBPP_ST_DONE: begin
          strap_st_r <= QBPP_ST_DONE;
        end
        default: begin
          strap_st_r <= QBPP_ST_WAIT;
        end
      endcase
    end
  end

endmodule : qbpp_top

// ### include/qbpp_params.svh
`ifndef QBPP_PARAMS_SVH
`define QBPP_PARAMS_SVH

// ============================================================
// Clock and timing
`define QBPP_CLK_MHZ 40
// Strong high driver on-time after a latch rises, in ns
`define QBPP_STRONG_HI_NS 50
// Least time, so round up to whole cycles
`define QBPP_STRONG_HI_CYC \
  ((`QBPP_STRONG_HI_NS * `QBPP_CLK_MHZ + 999) / 1000)

// ============================================================
// Widths and reset values
`define QBPP_PORT_WIDTH 8
`define QBPP_LATCH_RST 8'hFF

// ============================================================
// Bit positions on the alternate-function port
`define QBPP_AF_SER_RX 0
`define QBPP_AF_SER_TX 1
`define QBPP_AF_IRQ_A 2
`define QBPP_AF_IRQ_B 3
`define QBPP_AF_TMR_A 4
`define QBPP_AF_TMR_B 5
`define QBPP_AF_XWR 6
`define QBPP_AF_XRD 7

`endif

// ### include/qbpp_pkg.sv
package qbpp_pkg;

  typedef logic [7:0] qbpp_byte_type;

  typedef enum logic [1:0] {
    QBPP_ST_WAIT,
    QBPP_ST_SYNC,
    QBPP_ST_DONE
  } qbpp_strap_state_type;

endpackage : qbpp_pkg

// ### rtl/qbpp_port_cell.sv
`timescale 1ns/10ps
`include "qbpp_params.svh"

module qbpp_port_cell #(
  parameter int WIDTH = `QBPP_PORT_WIDTH,
  parameter int HOLD = `QBPP_STRONG_HI_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_en,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [WIDTH-1:0] i_alt_sel,
  input wire logic [WIDTH-1:0] i_alt_val,
  input wire logic [WIDTH-1:0] i_strong_sel,
  input wire logic [WIDTH-1:0] i_pin_in,
  output logic [WIDTH-1:0] o_latch,
  output logic [WIDTH-1:0] o_pin_sync,
  output logic [WIDTH-1:0] o_pin_out,
  output logic [WIDTH-1:0] o_pin_oe_n,
  output logic [WIDTH-1:0] o_pullup
);

  localparam int CW = $clog2(HOLD + 1);

  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] eff;
  logic [WIDTH-1:0] eff_d_r;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] out_nxt;
  logic [WIDTH-1:0] oe_n_nxt;
  logic [WIDTH-1:0] pu_nxt;
  logic [CW-1:0] hold_r [WIDTH];

  // ============================================================
  // Port latch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_r <= {WIDTH{1'b1}}; // R1 R2
    end else if (i_wr_en) begin
      latch_r <= i_wr_data; // R4
    end
  end

  // Latch keeps its value while a function owns the pin
  assign eff = (i_alt_sel & i_alt_val) | (~i_alt_sel & latch_r); // R12
  assign rise = eff & ~eff_d_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eff_d_r <= {WIDTH{1'b1}};
    end else begin
      eff_d_r <= eff;
    end
  end

  // ============================================================
  // Strong high transition timer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int b = 0; b < WIDTH; b++) begin
        hold_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < WIDTH; b++) begin
        if (rise[b]) begin
          hold_r[b] <= CW'(HOLD); // R5
        end else if (hold_r[b] != '0) begin
          hold_r[b] <= hold_r[b] - 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Pin drive
  always_comb begin
    out_nxt = '1;
    oe_n_nxt = '1;
    pu_nxt = '1;
    for (int b = 0; b < WIDTH; b++) begin
      if (i_strong_sel[b]) begin
        out_nxt[b] = eff[b];
        oe_n_nxt[b] = 1'b0;
        pu_nxt[b] = 1'b0;
      end else if (!eff[b]) begin
        out_nxt[b] = 1'b0; // R4
        oe_n_nxt[b] = 1'b0; // R4
        pu_nxt[b] = 1'b0;
      end else if (rise[b] || hold_r[b] > CW'(1)) begin
        oe_n_nxt[b] = 1'b0; // R5
      end else begin
        // Weak pull-up only, so a driver outside wins
        oe_n_nxt[b] = 1'b1; // R3
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out <= {WIDTH{1'b1}}; // R1 R2
      o_pin_oe_n <= {WIDTH{1'b1}}; // R1 R2
      o_pullup <= {WIDTH{1'b1}}; // R1 R2
    end else begin
      o_pin_out <= out_nxt;
      o_pin_oe_n <= oe_n_nxt;
      o_pullup <= pu_nxt;
    end
  end

  // ============================================================
  // Pin level synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= {WIDTH{1'b1}};
      sync_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= i_pin_in;
      sync_r <= meta_r; // R13 R3
    end
  end

  assign o_pin_sync = sync_r;
  assign o_latch = latch_r;

endmodule : qbpp_port_cell

// ### tb/qbpp_pin_model.sv
`timescale 1ns/10ps

// ============================================================
// Outside circuits on one port: their drive beats the weak pull-up
module qbpp_pin_model (
  input wire qbpp_pkg::qbpp_byte_type i_out,
  input wire qbpp_pkg::qbpp_byte_type i_oe_n,
  input wire qbpp_pkg::qbpp_byte_type i_pullup,
  input wire qbpp_pkg::qbpp_byte_type i_ext_en,
  input wire qbpp_pkg::qbpp_byte_type i_ext_val,
  output qbpp_pkg::qbpp_byte_type o_pin
);
  // Floating and unpulled shows the inverse, so no stale level passes
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext_en & i_ext_val)
    | (i_oe_n & ~i_ext_en & (i_pullup | ~i_out));
endmodule : qbpp_pin_model

// ### tb/qbpp_monitor.sv
`timescale 1ns/10ps

// ============================================================
// Port checker
module qbpp_monitor #(
  parameter int HOLD = 2
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_HI_ADDR_EN,
  input wire qbpp_pkg::qbpp_byte_type I_HI_ADDR,
  input wire qbpp_pkg::qbpp_byte_type I_HI_PIN_IN,
  input wire qbpp_pkg::qbpp_byte_type O_HI_PIN_OUT,
  input wire qbpp_pkg::qbpp_byte_type O_HI_PIN_OE_N,
  input wire qbpp_pkg::qbpp_byte_type O_HI_PULLUP,
  input wire qbpp_pkg::qbpp_byte_type O_HI_PIN_READ,
  input wire qbpp_pkg::qbpp_byte_type O_HI_LATCH,
  input wire logic I_AF_WR_EN,
  input wire qbpp_pkg::qbpp_byte_type I_AF_WR_DATA,
  input wire qbpp_pkg::qbpp_byte_type I_AF_ALT_EN,
  input wire qbpp_pkg::qbpp_byte_type I_AF_PIN_IN,
  input wire logic I_SERIAL0_TRANSMIT_OUT,
  input wire qbpp_pkg::qbpp_byte_type O_AF_PIN_OUT,
  input wire qbpp_pkg::qbpp_byte_type O_AF_PIN_OE_N,
  input wire qbpp_pkg::qbpp_byte_type O_AF_PULLUP,
  input wire qbpp_pkg::qbpp_byte_type O_AF_LATCH,
  input wire logic O_EXT_IRQ_IN_A,
  input wire logic I_EXTERNAL_FETCH_STRAP,
  input wire logic O_FETCH_EXTERNAL,
  input wire logic O_FETCH_READY
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_rst_hi;
    $rose(I_RST_N) |-> O_HI_PULLUP == 8'hFF && O_HI_PIN_OE_N == 8'hFF;
  endproperty
  a_rst_hi: assert property (p_rst_hi) else $error("hi port reset");
  property p_rst_af;
    $rose(I_RST_N) |-> O_AF_PULLUP == 8'hFF && O_AF_PIN_OE_N == 8'hFF;
  endproperty
  a_rst_af: assert property (p_rst_af) else $error("af port reset");
  property p_low;
    (!O_HI_LATCH[0] && !I_HI_ADDR_EN) [*3] |->
      !O_HI_PIN_OE_N[0] && !O_HI_PIN_OUT[0];
  endproperty
  a_low: assert property (p_low) else $error("no pull-down");
  // Pulse length assumes HOLD of 2
  property p_rise;
    $rose(O_HI_LATCH[0]) && !I_HI_ADDR_EN |=>
      (O_HI_PIN_OUT[0] && !O_HI_PIN_OE_N[0]) [*2] ##1
      (O_HI_PIN_OE_N[0] && O_HI_PULLUP[0]);
  endproperty
  a_rise: assert property (p_rise) else $error("bad high pulse");
  property p_bus;
    (I_HI_ADDR_EN ##1 I_HI_ADDR_EN && $stable(I_HI_ADDR)) |=>
      O_HI_PIN_OUT == $past(I_HI_ADDR) && O_HI_PIN_OE_N == 8'h00;
  endproperty
  a_bus: assert property (p_bus) else $error("address not out");
  property p_read;
    O_HI_PIN_READ == $past(I_HI_PIN_IN, 2);
  endproperty
  a_read: assert property (p_read) else $error("pin read wrong");
  property p_irq;
    I_AF_ALT_EN[2] [*4] |-> O_EXT_IRQ_IN_A == $past(I_AF_PIN_IN[2], 3);
  endproperty
  a_irq: assert property (p_irq) else $error("irq input wrong");
  property p_tx;
    (I_AF_ALT_EN[1] && !I_SERIAL0_TRANSMIT_OUT) [*3] |->
      !O_AF_PIN_OE_N[1] && !O_AF_PIN_OUT[1];
  endproperty
  a_tx: assert property (p_tx) else $error("transmit not out");
  property p_keep;
    I_AF_ALT_EN[1] && I_AF_WR_EN |=> O_AF_LATCH[1] == $past(I_AF_WR_DATA[1]);
  endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  property p_strap;
    $rose(O_FETCH_READY) |-> O_FETCH_EXTERNAL == !I_EXTERNAL_FETCH_STRAP;
  endproperty
  a_strap: assert property (p_strap) else $error("fetch source");
  c_bus: cover property (I_HI_ADDR_EN [*3]);
  c_irq: cover property (I_AF_ALT_EN[2] [*4]);
  c_ext: cover property ($rose(O_FETCH_READY) && O_FETCH_EXTERNAL);
endmodule : qbpp_monitor

// ### tb/qbpp_top_bench.sv
`timescale 1ns/10ps

module qbpp_top_bench;
  import qbpp_pkg::*;
  logic I_CORE_CLK, I_RST_N, I_HI_WR_EN, I_HI_ADDR_EN, I_AF_WR_EN;
  logic I_SERIAL0_TRANSMIT_OUT, I_XMEM_WR_STROBE_N, I_XMEM_RD_STROBE_N;
  logic I_EXTERNAL_FETCH_STRAP, O_SERIAL0_RECEIVE_IN, O_EXT_IRQ_IN_A;
  logic O_EXT_IRQ_IN_B, O_TIMER_A_COUNT_IN, O_TIMER_B_COUNT_IN;
  logic O_FETCH_EXTERNAL, O_FETCH_READY;
  qbpp_byte_type I_HI_WR_DATA, I_HI_ADDR, I_HI_PIN_IN, O_HI_PIN_OUT;
  qbpp_byte_type O_HI_PIN_OE_N, O_HI_PULLUP, O_HI_PIN_READ, O_HI_LATCH;
  qbpp_byte_type I_AF_WR_DATA, I_AF_ALT_EN, I_AF_PIN_IN, O_AF_PIN_OUT;
  qbpp_byte_type O_AF_PIN_OE_N, O_AF_PULLUP, O_AF_PIN_READ, O_AF_LATCH;
  qbpp_byte_type hi_ext_en, hi_ext_val, af_ext_en, af_ext_val;
  int n_mismatch, num_checks;

  qbpp_top u_qbpp_top (.*);
  qbpp_pin_model u_qbpp_pin_model (.i_out(O_HI_PIN_OUT),
    .i_oe_n(O_HI_PIN_OE_N), .i_pullup(O_HI_PULLUP), .i_ext_en(hi_ext_en),
    .i_ext_val(hi_ext_val), .o_pin(I_HI_PIN_IN));
  qbpp_pin_model u_qbpp_pin_model_af (.i_out(O_AF_PIN_OUT),
    .i_oe_n(O_AF_PIN_OE_N), .i_pullup(O_AF_PULLUP), .i_ext_en(af_ext_en),
    .i_ext_val(af_ext_val), .o_pin(I_AF_PIN_IN));

  // ============================================================
  // Shared tasks
  task chk(input qbpp_byte_type g, input qbpp_byte_type e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge I_CORE_CLK);
    #1;
  endtask : tick
  task wr(input bit hi, input qbpp_byte_type d);
    @(posedge I_CORE_CLK);
    I_HI_WR_EN <= hi;
    I_AF_WR_EN <= !hi;
    I_HI_WR_DATA <= d;
    I_AF_WR_DATA <= d;
    @(posedge I_CORE_CLK);
    I_HI_WR_EN <= 1'b0;
    I_AF_WR_EN <= 1'b0;
  endtask : wr
  task do_reset(input logic s);
    @(posedge I_CORE_CLK);
    I_RST_N <= 1'b0;
    I_EXTERNAL_FETCH_STRAP <= s;
    repeat (16) @(posedge I_CORE_CLK);
    I_RST_N <= 1'b1;
    tick(4);
  endtask : do_reset
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // ============================================================
  // Scenarios
  task t_reset;
    do_reset(1'b1);
    chk(O_HI_PULLUP, 8'hFF);
    chk(O_AF_PULLUP, 8'hFF);
    chk(O_AF_PIN_OE_N, 8'hFF);
    chk({6'h00, O_FETCH_READY, O_FETCH_EXTERNAL}, 8'h02);
    $display("t_reset done");
  endtask : t_reset
  task t_latch;
    wr(1, 8'hFE);
    tick(1);
    chk(O_HI_PIN_OE_N, 8'hFE);
    chk(O_HI_PULLUP, 8'hFE);
    wr(1, 8'hFF);
    tick(1);
    chk(O_HI_PIN_OE_N, 8'hFE);
    chk(O_HI_PIN_OUT, 8'hFF);
    tick(2);
    chk(O_HI_PIN_OE_N, 8'hFF);
    @(posedge I_CORE_CLK);
    hi_ext_en <= 8'h08;
    tick(3);
    chk(O_HI_PIN_READ, 8'hF7);
    chk(O_HI_LATCH, 8'hFF);
    @(posedge I_CORE_CLK);
    hi_ext_en <= 8'h00;
    $display("t_latch done");
  endtask : t_latch
  task t_bus;
    @(posedge I_CORE_CLK);
    I_HI_ADDR_EN <= 1'b1;
    I_HI_ADDR <= 8'h5A;
    wr(1, 8'h3C);
    tick(2);
    chk(O_HI_PIN_OUT, 8'h5A);
    chk(O_HI_LATCH, 8'h3C);
    @(posedge I_CORE_CLK);
    I_HI_ADDR_EN <= 1'b0;
    tick(6);
    chk(O_HI_PIN_OE_N, 8'h3C);
    wr(1, 8'hFF);
    tick(4);
    $display("t_bus done");
  endtask : t_bus
  task t_alt;
    @(posedge I_CORE_CLK);
    I_AF_ALT_EN <= 8'hFF;
    I_SERIAL0_TRANSMIT_OUT <= 1'b0;
    I_XMEM_WR_STROBE_N <= 1'b0;
    af_ext_en <= 8'h3D;
    af_ext_val <= 8'h28;
    wr(0, 8'h00);
    tick(5);
    chk(O_AF_PIN_OE_N, 8'hBD);
    chk(O_AF_PIN_OUT & 8'h42, 8'h00);
    chk(O_AF_LATCH, 8'h00);
    chk(O_AF_PIN_READ, 8'hA8);
    chk({3'h0, O_SERIAL0_RECEIVE_IN, O_EXT_IRQ_IN_A, O_EXT_IRQ_IN_B,
      O_TIMER_A_COUNT_IN, O_TIMER_B_COUNT_IN}, 8'h05);
    @(posedge I_CORE_CLK);
    I_XMEM_RD_STROBE_N <= 1'b0;
    tick(3);
    chk(O_AF_PIN_OE_N, 8'h3D);
    @(posedge I_CORE_CLK);
    I_AF_ALT_EN <= 8'h00;
    af_ext_en <= 8'h00;
    {I_SERIAL0_TRANSMIT_OUT, I_XMEM_WR_STROBE_N, I_XMEM_RD_STROBE_N} <= '1;
    tick(4);
    chk({3'h0, O_SERIAL0_RECEIVE_IN, O_EXT_IRQ_IN_A, O_EXT_IRQ_IN_B,
      O_TIMER_A_COUNT_IN, O_TIMER_B_COUNT_IN}, 8'h1F);
    chk(O_AF_PIN_OE_N, 8'h00);
    wr(0, 8'hFF);
    tick(4);
    $display("t_alt done");
  endtask : t_alt
  task t_strap;
    do_reset(1'b0);
    chk({6'h00, O_FETCH_READY, O_FETCH_EXTERNAL}, 8'h03);
    $display("t_strap done");
  endtask : t_strap

  // ============================================================
  // Clock, sequence and watchdog
  initial begin
    I_CORE_CLK = 1'b0;
    forever #12.5 I_CORE_CLK = ~I_CORE_CLK;
  end
  initial begin
    {I_RST_N, I_HI_WR_EN, I_HI_ADDR_EN, I_AF_WR_EN} = '0;
    {I_SERIAL0_TRANSMIT_OUT, I_XMEM_WR_STROBE_N, I_XMEM_RD_STROBE_N} = '1;
    I_EXTERNAL_FETCH_STRAP = 1'b1;
    {I_HI_WR_DATA, I_HI_ADDR, I_AF_WR_DATA, I_AF_ALT_EN} = '0;
    {hi_ext_en, hi_ext_val, af_ext_en, af_ext_val} = '0;
    t_reset();
    t_latch();
    t_bus();
    t_alt();
    t_strap();
    stop_test();
  end
  // Whole run is near 100 cycles; 2000 leaves wide margin
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end
endmodule : qbpp_top_bench

bind qbpp_top qbpp_monitor #(.HOLD(HOLD)) u_qbpp_monitor (.*);
